// ==== fbs_scanner_status.v ====
// Fieldbus scanner status, indication and master scan logic with an APB register slave.
// Notes on behaviour
// - Network indicator dark off-line, green with a node, flashing green without.
// - Network indicator steady red on an unrecoverable fault.
// - Network indicator flashes red on node timeout or recoverable fault.
// - Scanner indicator dark in reset, green active, flashing green healthy idle.
// - Scanner red on error, flashing red bad config, orange in download mode.
// - Receive indicator flickers while configuration data arrives, else dark.
// - Transmit indicator flickers while configuration data leaves, else dark.
// - Diagnostic indicator lit only while built-in diagnostic tests run.
// - Network bit rate of 125, 250 or 500 kbaud from configuration.
// - Up to 63 slave nodes, each with its own memory image entries.
// - While scanning, image data is exchanged continually with the nodes.
// - The module is the only master and starts every exchange.
`include "fbs_regs.vh"
module fbs_scanner_status #(
    parameter integer NODES = 63,
    parameter integer FLASH_HALF_CYC = `FBS_FLASH_HALF_CYC,
    parameter integer STRETCH_CYC = `FBS_STRETCH_CYC,
    parameter integer DIAGNOSTIC_INDICATOR_CYC = `FBS_DIAGNOSTIC_INDICATOR_CYC,
    parameter integer RSP_TMO_CYC = `FBS_RSP_TMO_CYC
) (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    output wire irq,
    input wire cfg_rxd,
    input wire cfg_txd,
    output reg req_valid,
    input wire req_ready,
    output reg [5:0] req_node,
    output reg [7:0] req_data,
    input wire rsp_valid,
    input wire [5:0] rsp_node,
    input wire [7:0] rsp_data,
    output reg [8:0] bit_div,
    output reg net_led_green,
    output reg net_led_red,
    output reg scan_led_green,
    output reg scan_led_red,
    output reg cfg_rx_led,
    output reg cfg_tx_led,
    output reg diagnostic_indicator
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_REQ = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;
    localparam integer DIV_125 = `FBS_CLK_HZ / `FBS_BAUD_125;
    localparam integer DIV_250 = `FBS_CLK_HZ / `FBS_BAUD_250;
    localparam integer DIV_500 = `FBS_CLK_HZ / `FBS_BAUD_500;

    reg [8:0] ctrl_r;
    reg [5:0] sel_r;
    reg [62:0] node_en_r;
    reg [3:0] int_stat_r;
    reg [3:0] int_en_r;
    reg [7:0] out_img [0:62];
    reg [7:0] in_img [0:62];
    reg [62:0] conn_r;
    reg [62:0] tmo_r;
    reg [2:0] state_r;
    reg [5:0] idx_r;
    reg [31:0] wait_r;
    reg [31:0] flash_cnt_r;
    reg flash_r;
    reg [31:0] diagnostic_indicator_cnt_r;
    reg diagnostic_indicator_busy_r;
    reg [3:0] ev_w;
    reg [31:0] rd_w;
    reg map_w;
    wire setup_w;
    wire wr_w;
    wire rx_act_w;
    wire tx_act_w;
    wire [1:0] rate_w;
    wire cfg_bad_w;
    wire scanning_w;
    wire [5:0] last_w;
    integer i;

    assign setup_w = psel & ~penable;
    assign wr_w = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~map_w;
    assign irq = |(int_stat_r & int_en_r);
    assign rate_w = ctrl_r[`FBS_CTRL_RATE_HI:`FBS_CTRL_RATE_LO];
    // The fourth rate code is not a valid rate, so it counts as bad downloaded data.
    assign cfg_bad_w = (rate_w != `FBS_RATE_125) && (rate_w != `FBS_RATE_250) && (rate_w != `FBS_RATE_500);
    // Scanning needs a valid configuration and stops during a download.
    assign scanning_w = ctrl_r[`FBS_CTRL_SCAN] & ctrl_r[`FBS_CTRL_ONLINE] & ~ctrl_r[`FBS_CTRL_CFGMODE]
        & ~cfg_bad_w & ~ctrl_r[`FBS_CTRL_HWERR] & ~ctrl_r[`FBS_CTRL_FATAL];
    assign last_w = NODES[5:0] - 6'h01;

    // Read mux and address decode.
    always @* begin
        rd_w = 32'h00000000;
        map_w = 1'b1;
        case (paddr)
            `FBS_CTRL: rd_w = {23'h000000, ctrl_r};
            `FBS_STAT: rd_w = {16'h0000, 2'h0, idx_r, 4'h0, cfg_bad_w, diagnostic_indicator_busy_r, |tmo_r, |conn_r};
            `FBS_NODE_SEL: rd_w = {26'h0000000, sel_r};
            `FBS_NODE_OUT: rd_w = {24'h000000, out_img[sel_r]};
            `FBS_NODE_IN: rd_w = {24'h000000, in_img[sel_r]};
            `FBS_INT_STAT: rd_w = {28'h0000000, int_stat_r};
            `FBS_INT_CLR: rd_w = 32'h00000000;
            `FBS_INT_EN: rd_w = {28'h0000000, int_en_r};
            `FBS_NODE_EN_LO: rd_w = node_en_r[31:0];
            `FBS_NODE_EN_HI: rd_w = {1'b0, node_en_r[62:32]};
            default: map_w = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so it stands from a flop in the access cycle.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (setup_w && !pwrite) begin
            prdata <= rd_w;
        end
    end

    // Software registers; the diagnostic start bit does not stay set.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= `FBS_CTRL_RST;
            sel_r <= 6'h00;
            node_en_r <= 63'h0;
            int_en_r <= 4'h0;
        end else begin
            ctrl_r[`FBS_CTRL_DIAGNOSTIC_INDICATOR] <= 1'b0;
            if (wr_w) begin
                case (paddr)
                    `FBS_CTRL: ctrl_r <= pwdata[8:0];
                    `FBS_NODE_SEL: sel_r <= (pwdata[5:0] > last_w) ? last_w : pwdata[5:0];
                    `FBS_INT_EN: int_en_r <= pwdata[3:0];
                    `FBS_NODE_EN_LO: node_en_r[31:0] <= pwdata;
                    `FBS_NODE_EN_HI: node_en_r[62:32] <= pwdata[30:0];
                    default: ;
                endcase
            end
        end
    end

    // Host side of the memory image: one output byte per node.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            for (i = 0; i < 63; i = i + 1) begin
                out_img[i] <= 8'h00;
            end
        end else if (wr_w && paddr == `FBS_NODE_OUT) begin
            out_img[sel_r] <= pwdata[7:0];
        end
    end

    // Bit time in module clocks for the selected rate.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            bit_div <= 9'h000;
        end else begin
            case (rate_w)
                `FBS_RATE_125: bit_div <= DIV_125[8:0];
                `FBS_RATE_250: bit_div <= DIV_250[8:0];
                `FBS_RATE_500: bit_div <= DIV_500[8:0];
                default: bit_div <= 9'h000;
            endcase
        end
    end

    // Master scan: each enabled node is polled in turn; nodes never speak unasked.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            idx_r <= 6'h00;
            wait_r <= 32'h00000000;
            req_valid <= 1'b0;
            req_node <= 6'h00;
            req_data <= 8'h00;
            conn_r <= 63'h0;
            tmo_r <= 63'h0;
            ev_w <= 4'h0;
            for (i = 0; i < 63; i = i + 1) begin
                in_img[i] <= 8'h00;
            end
        end else begin
            ev_w <= 4'h0;
            case (state_r)
                ST_IDLE: begin
                    if (!scanning_w) begin
                        conn_r <= 63'h0;
                    end else if (node_en_r[idx_r]) begin
                        req_valid <= 1'b1;
                        req_node <= idx_r;
                        req_data <= out_img[idx_r];
                        state_r <= ST_REQ;
                    end else begin
                        ev_w[`FBS_INT_SCAN_DONE] <= (idx_r == last_w);
                        idx_r <= (idx_r == last_w) ? 6'h00 : idx_r + 6'h01;
                    end
                end
                ST_REQ: begin
                    if (req_ready) begin
                        req_valid <= 1'b0;
                        wait_r <= 32'h00000000;
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    wait_r <= wait_r + 32'h00000001;
                    if (rsp_valid && rsp_node == idx_r) begin
                        in_img[idx_r] <= rsp_data;
                        conn_r[idx_r] <= 1'b1;
                        tmo_r[idx_r] <= 1'b0;
                        ev_w[`FBS_INT_NODE_UP] <= ~conn_r[idx_r];
                        ev_w[`FBS_INT_SCAN_DONE] <= (idx_r == last_w);
                        idx_r <= (idx_r == last_w) ? 6'h00 : idx_r + 6'h01;
                        state_r <= ST_IDLE;
                    end else if (wait_r >= RSP_TMO_CYC - 1) begin
                        conn_r[idx_r] <= 1'b0;
                        tmo_r[idx_r] <= 1'b1;
                        ev_w[`FBS_INT_NODE_TMO] <= 1'b1;
                        ev_w[`FBS_INT_SCAN_DONE] <= (idx_r == last_w);
                        idx_r <= (idx_r == last_w) ? 6'h00 : idx_r + 6'h01;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    req_valid <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Sticky interrupt status; a new event in the clear cycle survives the clear.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            int_stat_r <= 4'h0;
        end else if (wr_w && paddr == `FBS_INT_CLR) begin
            int_stat_r <= (int_stat_r & ~pwdata[3:0]) | ev_w;
        end else begin
            int_stat_r <= int_stat_r | ev_w;
        end
    end

    // Common flash clock for every flashing indicator.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            flash_cnt_r <= 32'h00000000;
            flash_r <= 1'b0;
        end else if (flash_cnt_r >= FLASH_HALF_CYC - 1) begin
            flash_cnt_r <= 32'h00000000;
            flash_r <= ~flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h00000001;
        end
    end

    // Diagnostics run once after reset and again on each software start.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            diagnostic_indicator_cnt_r <= 32'h00000000;
            diagnostic_indicator_busy_r <= 1'b1;
            diagnostic_indicator <= 1'b0;
        end else begin
            diagnostic_indicator <= diagnostic_indicator_busy_r;
            if (ctrl_r[`FBS_CTRL_DIAGNOSTIC_INDICATOR]) begin
                diagnostic_indicator_cnt_r <= 32'h00000000;
                diagnostic_indicator_busy_r <= 1'b1;
            end else if (diagnostic_indicator_busy_r) begin
                diagnostic_indicator_cnt_r <= diagnostic_indicator_cnt_r + 32'h00000001;
                if (diagnostic_indicator_cnt_r >= DIAGNOSTIC_INDICATOR_CYC - 1) begin
                    diagnostic_indicator_busy_r <= 1'b0;
                end
            end
        end
    end

    // The receive pin is asynchronous and is synchronised; the transmit line is already on this clock.
    fbs_stretch #(.SYNC(1), .CYC(STRETCH_CYC)) u_rx_act (
        .sys_clk(sys_clk), .rst_n(rst_n), .line_in(cfg_rxd), .act_out(rx_act_w)
    );

    fbs_stretch #(.SYNC(0), .CYC(STRETCH_CYC)) u_tx_act (
        .sys_clk(sys_clk), .rst_n(rst_n), .line_in(cfg_txd), .act_out(tx_act_w)
    );

    // Indicator encoding; reset holds every indicator dark.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            net_led_green <= 1'b0;
            net_led_red <= 1'b0;
            scan_led_green <= 1'b0;
            scan_led_red <= 1'b0;
            cfg_rx_led <= 1'b0;
            cfg_tx_led <= 1'b0;
        end else begin
            cfg_rx_led <= rx_act_w;
            cfg_tx_led <= tx_act_w;
            if (ctrl_r[`FBS_CTRL_FATAL]) begin
                net_led_green <= 1'b0;
                net_led_red <= 1'b1;
            end else if (!ctrl_r[`FBS_CTRL_ONLINE]) begin
                net_led_green <= 1'b0;
                net_led_red <= 1'b0;
            end else if (ctrl_r[`FBS_CTRL_RECOV] || (|tmo_r)) begin
                net_led_green <= 1'b0;
                net_led_red <= flash_r;
            end else begin
                net_led_green <= (|conn_r) ? 1'b1 : flash_r;
                net_led_red <= 1'b0;
            end
            if (ctrl_r[`FBS_CTRL_HWERR]) begin
                scan_led_green <= 1'b0;
                scan_led_red <= 1'b1;
            end else if (ctrl_r[`FBS_CTRL_CFGMODE]) begin
                scan_led_green <= 1'b1;
                scan_led_red <= 1'b1;
            end else if (cfg_bad_w) begin
                scan_led_green <= 1'b0;
                scan_led_red <= flash_r;
            end else begin
                scan_led_green <= scanning_w ? 1'b1 : flash_r;
                scan_led_red <= 1'b0;
            end
        end
    end
endmodule // fbs_scanner_status

// ==== fbs_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the fieldbus scanner status block.
`ifndef FBS_REGS_VH
`define FBS_REGS_VH
`define FBS_ADDR_W 8
`define FBS_CTRL 8'h00
`define FBS_STAT 8'h04
`define FBS_NODE_SEL 8'h08
`define FBS_NODE_OUT 8'h0c
`define FBS_NODE_IN 8'h10
`define FBS_INT_STAT 8'h14
`define FBS_INT_CLR 8'h18
`define FBS_INT_EN 8'h1c
`define FBS_NODE_EN_LO 8'h20
`define FBS_NODE_EN_HI 8'h24
`define FBS_CTRL_ONLINE 0
`define FBS_CTRL_SCAN 1
`define FBS_CTRL_CFGMODE 2
`define FBS_CTRL_DIAGNOSTIC_INDICATOR 3
`define FBS_CTRL_RATE_LO 4
`define FBS_CTRL_RATE_HI 5
`define FBS_CTRL_HWERR 6
`define FBS_CTRL_FATAL 7
`define FBS_CTRL_RECOV 8
`define FBS_CTRL_RST 9'h000
`define FBS_RATE_125 2'h0
`define FBS_RATE_250 2'h1
`define FBS_RATE_500 2'h2
`define FBS_INT_NODE_TMO 0
`define FBS_INT_NODE_UP 1
`define FBS_INT_DIAGNOSTIC_INDICATOR_DONE 2
`define FBS_INT_SCAN_DONE 3
`define FBS_CLK_HZ 20000000
`define FBS_CLK_NS 50
`define FBS_BAUD_125 125000
`define FBS_BAUD_250 250000
`define FBS_BAUD_500 500000
`define FBS_FLASH_HALF_NS 500000000
`define FBS_FLASH_HALF_CYC (`FBS_FLASH_HALF_NS / `FBS_CLK_NS)
`define FBS_STRETCH_NS 50000000
`define FBS_STRETCH_CYC (`FBS_STRETCH_NS / `FBS_CLK_NS)
`define FBS_DIAGNOSTIC_INDICATOR_NS 100000000
`define FBS_DIAGNOSTIC_INDICATOR_CYC (`FBS_DIAGNOSTIC_INDICATOR_NS / `FBS_CLK_NS)
`define FBS_RSP_TMO_NS 1000000
`define FBS_RSP_TMO_CYC (`FBS_RSP_TMO_NS / `FBS_CLK_NS)
`endif

// ==== fbs_stretch.v ====
// Activity detector that stretches short low-going serial activity into a visible indicator pulse.
module fbs_stretch #(
    parameter SYNC = 1,
    parameter integer CYC = 1000000
) (
    input wire sys_clk,
    input wire rst_n,
    input wire line_in,
    output wire act_out
);
    reg s1_r;
    reg s2_r;
    reg [23:0] cnt_r;
    wire line_w;

    // Unused stages still clock the line in but go unread when it is already in the clock domain.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end else begin
            s1_r <= line_in;
            s2_r <= s1_r;
        end
    end

    assign line_w = (SYNC != 0) ? s2_r : line_in;

    // A start bit or any low data bit reloads the hold time, so a lone byte stays visible.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= 24'h000000;
        end else if (!line_w) begin
            cnt_r <= CYC[23:0];
        end else if (cnt_r != 24'h000000) begin
            cnt_r <= cnt_r - 24'h000001;
        end
    end

    assign act_out = (cnt_r != 24'h000000);
endmodule // fbs_stretch

// ==== fbs_status_checker.sv ====
// Port-level assertions and covers for the fieldbus scanner status block.
module fbs_status_checker #(
    parameter integer STRETCH_CYC = 4,
    parameter integer DIAGNOSTIC_INDICATOR_CYC = 10
) (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire cfg_rxd,
    input wire cfg_txd,
    input wire req_valid,
    input wire req_ready,
    input wire [5:0] req_node,
    input wire [7:0] req_data,
    input wire [8:0] bit_div,
    input wire net_led_green,
    input wire net_led_red,
    input wire scan_led_green,
    input wire scan_led_red,
    input wire cfg_rx_led,
    input wire cfg_tx_led,
    input wire diagnostic_indicator
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    reg [31:0] diagnostic_indicator_cnt_r;
    reg [31:0] rx_idle_r;
    reg [31:0] tx_idle_r;
    // Idle counters saturate so a long quiet spell cannot wrap back into the flicker window.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            diagnostic_indicator_cnt_r <= 32'h0;
            rx_idle_r <= 32'h0;
            tx_idle_r <= 32'h0;
        end else begin
            diagnostic_indicator_cnt_r <= diagnostic_indicator ? diagnostic_indicator_cnt_r + 32'h1 : 32'h0;
            rx_idle_r <= !cfg_rxd ? 32'h0 : (rx_idle_r[7] ? rx_idle_r : rx_idle_r + 32'h1);
            tx_idle_r <= !cfg_txd ? 32'h0 : (tx_idle_r[7] ? tx_idle_r : tx_idle_r + 32'h1);
        end
    end
    chk_pready_high: assert property (pready) else $error("pready low");
    chk_apb_error: assert property (psel && penable |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    chk_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_node) && $stable(req_data))
        else $error("poll request changed before acceptance");
    chk_req_single: assert property (req_valid && req_ready |=> !req_valid)
        else $error("second poll while one outstanding");
    chk_node_range: assert property (req_valid |-> req_node != 6'h3f)
        else $error("poll of node beyond 62");
    chk_net_color: assert property (!(net_led_green && net_led_red))
        else $error("network indicator shows two colours");
    chk_reset_dark: assert property ($rose(rst_n) |-> !(net_led_green || net_led_red || scan_led_green || scan_led_red))
        else $error("indicator lit out of reset");
    chk_rx_flicker: assert property (!cfg_rxd |-> ##[1:5] cfg_rx_led)
        else $error("receive indicator missed activity");
    chk_rx_dark: assert property (rx_idle_r > STRETCH_CYC + 6 |-> !cfg_rx_led)
        else $error("receive indicator lit while idle");
    chk_tx_flicker: assert property (!cfg_txd |-> ##[1:5] cfg_tx_led)
        else $error("transmit indicator missed activity");
    chk_tx_dark: assert property (tx_idle_r > STRETCH_CYC + 6 |-> !cfg_tx_led)
        else $error("transmit indicator lit while idle");
    chk_diagnostic_indicator_span: assert property ($fell(diagnostic_indicator) |-> diagnostic_indicator_cnt_r == DIAGNOSTIC_INDICATOR_CYC)
        else $error("diagnostic indicator span wrong");
    chk_rate_div: assert property (bit_div inside {9'h0a0, 9'h050, 9'h028, 9'h000})
        else $error("bit divider not a supported rate");
    cover property (req_valid && req_ready);
    cover property (scan_led_green && scan_led_red);
    cover property ($fell(diagnostic_indicator));
endmodule // fbs_status_checker

bind fbs_scanner_status fbs_status_checker #(.STRETCH_CYC(STRETCH_CYC), .DIAGNOSTIC_INDICATOR_CYC(DIAGNOSTIC_INDICATOR_CYC)) fbs_status_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .cfg_rxd(cfg_rxd), .cfg_txd(cfg_txd), .req_valid(req_valid), .req_ready(req_ready),
    .req_node(req_node), .req_data(req_data), .bit_div(bit_div), .net_led_green(net_led_green),
    .net_led_red(net_led_red), .scan_led_green(scan_led_green), .scan_led_red(scan_led_red),
    .cfg_rx_led(cfg_rx_led), .cfg_tx_led(cfg_tx_led), .diagnostic_indicator(diagnostic_indicator));

// ==== fbs_node_model.sv ====
// Behavioural model of the slave nodes on the far side of the poll link.
module fbs_node_model (
    input wire sys_clk,
    input wire rst_n,
    input wire req_valid,
    input wire [5:0] req_node,
    input wire [7:0] req_data,
    input wire slow,
    input wire [6:0] mute_node,
    output reg req_ready,
    output reg rsp_valid,
    output reg [5:0] rsp_node,
    output reg [7:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] st_r;
    reg [3:0] cnt_r;
    reg [5:0] node_r;
    reg [7:0] data_r;
    always @(posedge sys_clk) begin
        req_ready <= 1'b0;
        rsp_valid <= 1'b0;
        // Lines toggle between answers so a stale byte can never match by luck.
        rsp_node <= ~rsp_node;
        rsp_data <= ~rsp_data;
        if (!rst_n) begin
            st_r <= 2'h0;
            rsp_node <= 6'h0;
            rsp_data <= 8'h0;
        end else if (st_r == 2'h0) begin
            if (req_valid) begin
                st_r <= 2'h1;
                cnt_r <= slow ? 4'h3 : 4'h0;
            end
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else if (st_r == 2'h1) begin
            req_ready <= 1'b1;
            node_r <= req_node;
            data_r <= req_data;
            cnt_r <= slow ? 4'h6 : 4'h1;
            st_r <= 2'h2;
        end else begin
            st_r <= 2'h0;
            if ({1'b0, node_r} != mute_node) begin
                rsp_valid <= 1'b1;
                rsp_node <= node_r;
                rsp_data <= data_r + 8'h11;
            end
        end
    end
endmodule // fbs_node_model

// ==== fbs_scanner_status_tb_top.sv ====
// Self-checking bench of the fieldbus scanner status block.
`include "fbs_regs.vh"
module fbs_scanner_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg sys_clk, rst_n, psel, penable, pwrite, cfg_rxd, cfg_txd, slow;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd;
    reg [6:0] mute_node;
    wire pready, pslverr, irq, req_valid, req_ready, rsp_valid;
    wire net_led_green, net_led_red, scan_led_green, scan_led_red, cfg_rx_led, cfg_tx_led, diagnostic_indicator;
    wire [31:0] prdata;
    wire [5:0] req_node, rsp_node;
    wire [7:0] req_data, rsp_data;
    wire [8:0] bit_div;
    wire [3:0] leds = {net_led_green, net_led_red, scan_led_green, scan_led_red};
    int n_fail, comparisons, cyc, i;
    reg [8:0] divs [4] = '{9'h0a0, 9'h050, 9'h028, 9'h000};
    reg [31:0] ctl [6] = '{32'h0, 32'h1, 32'h5, 32'hc0, 32'h101, 32'h31};
    reg [7:0] lex [6] = '{8'h08, 8'h88, 8'h85, 8'h11, 8'h28, 8'h82};
    fbs_scanner_status #(.FLASH_HALF_CYC(8), .STRETCH_CYC(4), .DIAGNOSTIC_INDICATOR_CYC(10), .RSP_TMO_CYC(16)) fbs_scanner_status_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .cfg_rxd(cfg_rxd),
        .cfg_txd(cfg_txd), .req_valid(req_valid), .req_ready(req_ready), .req_node(req_node), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_node(rsp_node), .rsp_data(rsp_data), .bit_div(bit_div),
        .net_led_green(net_led_green), .net_led_red(net_led_red), .scan_led_green(scan_led_green),
        .scan_led_red(scan_led_red), .cfg_rx_led(cfg_rx_led), .cfg_tx_led(cfg_tx_led),
        .diagnostic_indicator(diagnostic_indicator));
    fbs_node_model fbs_node_model_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_node(req_node), .req_data(req_data),
        .slow(slow), .mute_node(mute_node), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_node(rsp_node),
        .rsp_data(rsp_data));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task stop_test;
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // The whole run is under a thousand cycles; the ceiling leaves ample margin.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test;
        end
    end
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Classifies each network and scanner indicator colour over 40 cycles, longer than two flash half periods: off, on or flashing.
    task look(input [7:0] e);
        reg [3:0] h, l;
        reg [7:0] s;
        reg x;
        int k;
        h = 4'h0;
        l = 4'h0;
        x = 1'b0;
        repeat (40) begin
            @(posedge sys_clk);
            h = h | leds;
            l = l | ~leds;
            x = x | $isunknown(leds);
        end
        for (k = 0; k < 4; k++) s[2*k+:2] = h[k] ? (l[k] ? 2'h2 : 2'h1) : 2'h0;
        chk("leds", x ? 32'hff : {24'h0, s}, {24'h0, e});
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, slow} = '0;
        {cfg_rxd, cfg_txd, mute_node, rst_n} = {2'h3, 7'h7f, 1'b0};
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("diagnostic_indicator_on", diagnostic_indicator, 1);
        repeat (15) @(posedge sys_clk);
        chk("diagnostic_indicator_off", diagnostic_indicator, 0);
        for (i = 0; i < 4; i++) begin
            apb(`FBS_CTRL, 1, (i << 4) | 1);
            repeat (2) @(posedge sys_clk);
            chk("bit_div", bit_div, divs[i]);
        end
        for (i = 0; i < 6; i++) begin
            apb(`FBS_CTRL, 1, ctl[i]);
            repeat (3) @(posedge sys_clk);
            look(lex[i]);
        end
        apb(`FBS_CTRL, 1, 32'h8);
        repeat (3) @(posedge sys_clk);
        chk("diagnostic_indicator_run", diagnostic_indicator, 1);
        repeat (15) @(posedge sys_clk);
        chk("diagnostic_indicator_end", diagnostic_indicator, 0);
        apb(8'h28, 0, 32'h0);
        chk("unmapped", rd, 32'h0);
        cfg_rxd <= 1'b0;
        cfg_txd <= 1'b0;
        repeat (2) @(posedge sys_clk);
        cfg_rxd <= 1'b1;
        cfg_txd <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("rx_led", cfg_rx_led, 1);
        chk("tx_led", cfg_tx_led, 1);
        repeat (15) @(posedge sys_clk);
        chk("rx_idle", cfg_rx_led, 0);
        chk("tx_idle", cfg_tx_led, 0);
        apb(`FBS_NODE_EN_LO, 1, 32'h5);
        apb(`FBS_NODE_EN_HI, 1, 32'h0);
        apb(`FBS_NODE_SEL, 1, 32'h2);
        apb(`FBS_NODE_OUT, 1, 32'h3c);
        apb(`FBS_INT_EN, 1, 32'h1);
        apb(`FBS_CTRL, 1, 32'h3);
        repeat (150) @(posedge sys_clk);
        look(8'h44);
        apb(`FBS_NODE_IN, 0, 32'h0);
        chk("node_in", rd, 32'h4d);
        chk("irq_quiet", irq, 0);
        mute_node <= 7'h2;
        slow <= 1'b1;
        repeat (150) @(posedge sys_clk);
        look(8'h24);
        chk("irq_tmo", irq, 1);
        apb(`FBS_INT_EN, 1, 32'h0);
        @(posedge sys_clk);
        chk("irq_masked", irq, 0);
        apb(`FBS_INT_EN, 1, 32'h1);
        apb(`FBS_CTRL, 1, 32'h1);
        repeat (40) @(posedge sys_clk);
        apb(`FBS_STAT, 0, 32'h0);
        chk("stat", rd & 32'hff, 32'h2);
        apb(`FBS_INT_STAT, 0, 32'h0);
        chk("int_raw", rd, 32'hb);
        apb(`FBS_NODE_SEL, 1, 32'h3f);
        apb(`FBS_NODE_SEL, 0, 32'h0);
        chk("sel_clamp", rd, 32'h3e);
        apb(`FBS_INT_CLR, 1, 32'hf);
        apb(`FBS_INT_STAT, 0, 32'h0);
        chk("int_stat", rd, 32'h0);
        chk("irq_clear", irq, 0);
        stop_test;
    end
endmodule // fbs_scanner_status_tb_top
